//--- inc/cdr_defs.vh
// Constants for the clock divisor and reference clock output block
`ifndef CDR_DEFS_VH
`define CDR_DEFS_VH

// ----------------------------------------------------------------------------
// Register word addresses (Avalon word address, one 32-bit word each)
// ----------------------------------------------------------------------------
`define CDR_ADDR_W          2
`define CDR_ADDR_CLOCK_DIVISOR_CONTROL     2'h0
`define CDR_ADDR_REFCTL     2'h1
`define CDR_ADDR_STATUS     2'h2

// ----------------------------------------------------------------------------
// Clock divisor control fields
// ----------------------------------------------------------------------------
`define CDR_CD_RECOVER      15
`define CDR_CD_RED_HI       14
`define CDR_CD_RED_LO       12
`define CDR_CD_PROCESSOR_CLOCK_REDUCTION_EN      11
`define CDR_CD_RCP_HI       10
`define CDR_CD_RCP_LO       8
`define CDR_CD_PLLD_HI      7
`define CDR_CD_PLLD_LO      6
`define CDR_CD_PRE_HI       4
`define CDR_CD_PRE_LO       0
`define CDR_CD_RST_RED      3'h3
`define CDR_CD_RST_PLLD     2'h1
`define CDR_RED_NONE        3'h0
`define CDR_PLLD_RSVD       2'h2

// ----------------------------------------------------------------------------
// Reference clock control fields
// ----------------------------------------------------------------------------
`define CDR_RC_ENABLE       15
`define CDR_RC_SLEEP_RUN    13
`define CDR_RC_SOURCE       12
`define CDR_RC_DIV_HI       11
`define CDR_RC_DIV_LO       8

// ----------------------------------------------------------------------------
// Divider widths
// ----------------------------------------------------------------------------
`define CDR_CNT_W           16
`define CDR_ONE16           16'h0001

`endif

//--- logic/cdr_pow2_div.v
// Power-of-two clock-enable divider, used for every ratio in the block
`include "cdr_defs.vh"

module cdr_pow2_div (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        ce,
    input  wire        run,
    input  wire [3:0]  shift,
    output reg         tick,
    output reg         level
);

    reg [`CDR_CNT_W-1:0] count_reg;
    wire [`CDR_CNT_W-1:0] half = `CDR_ONE16 << shift;

    // ------------------------------------------------------------------------
    // Tick marks the input pulse that completes the ratio, so callers can
    // gate it with that same pulse; a registered tick would lag one pulse
    // ------------------------------------------------------------------------
    always @* begin
        tick = run & ((count_reg + `CDR_ONE16) >= half);
    end

    // ------------------------------------------------------------------------
    // Counter; shift 0 gives a tick every input pulse
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 16'h0000;
            level     <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                count_reg <= 16'h0000;
                level     <= 1'b0;
            end else if (tick) begin
                count_reg <= 16'h0000;
                level     <= ~level;   // Square wave toggles each half
            end else begin
                count_reg <= count_reg + `CDR_ONE16;
            end
        end
    end

endmodule // cdr_pow2_div

//--- logic/cdr_avalon_regs.v
// Avalon-MM slave access generator with one wait state
`include "cdr_defs.vh"

module cdr_avalon_regs (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        ce,
    input  wire        avs_read,
    input  wire        avs_write,
    output wire        avs_waitrequest,
    output wire        do_write,
    output wire        do_read
);

    reg ack_reg;

    // ------------------------------------------------------------------------
    // Access completes one cycle after it is seen; ack clears afterwards
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
        end else if (ce) begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~(ack_reg & ce);
    assign do_write        = avs_write & ack_reg & ce;
    assign do_read         = avs_read & ack_reg & ce;

endmodule // cdr_avalon_regs

//--- logic/cdr_clock_divisor.v
// Clock divisor control and reference clock output generator
//
// Behaviour
// - Recovery bit set and interrupt arrives: hardware clears processor_clock_reduction enable.
// - Three-bit processor reduction field divides instruction clock, reset divide by 8.
// - Reduction field writable only while processor_clock_reduction enable is clear.
// - Setting processor_clock_reduction enable ignored while reduction field is zero.
// - Processor_clock_reduction enable applies reduction ratio; clear forces 1:1.
// - RC postscaler field: code 1 divides by 2, reset code divides by 1.
// - PLL output divider: 00 divides by 2, reset divides by 4, 10 reserved.
// - Sleep-run bit keeps reference output running in Sleep, else stops.
// - Four-bit divider selects power of two half period; 1111 gives output divide by 65536.
`include "cdr_defs.vh"

module cdr_clock_divisor (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        ce,
    // Avalon-MM slave
    input  wire [1:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Clock enables of the source clocks, sampled in this domain
    input  wire        fcy_tick,
    input  wire        rc_osc_tick,
    input  wire        pll_tick,
    input  wire        xtal_tick,
    input  wire        sys_tick,
    // System state
    input  wire        interrupt_event,
    input  wire        sleep_mode,
    // Generated clock enables and reference output
    output reg         periph_clk_tick,
    output wire        rc_osc_div_tick,
    output wire        pll_div_tick,
    output reg         refclk_out,
    output reg         refclk_out_en_n
);

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    reg        interrupt_recovery_reg;
    reg [2:0]  processor_clock_reduction_reg;
    reg        processor_clock_reduction_enable_reg;
    reg [2:0]  rc_osc_postscaler_reg;
    reg [1:0]  pll_output_divider_reg;
    reg [4:0]  pll_input_prescaler_reg;
    reg        refclk_out_enable_reg;
    reg        refclk_sleep_run_reg;
    reg        refclk_source_select_reg;
    reg [3:0]  refclk_divider_reg;

    wire       do_write;
    wire       do_read;
    wire [15:0] clock_divisor_control_word;
    wire [15:0] refctl_word;
    wire       wr_lo = avs_byteenable[0];
    wire       wr_hi = avs_byteenable[1];

    // ------------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------------
    cdr_avalon_regs u_bus (
        .clk             (clk),
        .reset_n         (reset_n),
        .ce              (ce),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_waitrequest (avs_waitrequest),
        .do_write        (do_write),
        .do_read         (do_read)
    );

    // Address match, used by several processes
    function sel;
        input [1:0] addr;
        input [1:0] target;
        begin
            sel = (addr == target);
        end
    endfunction

    wire wr_clock_divisor_control = do_write & sel(avs_address, `CDR_ADDR_CLOCK_DIVISOR_CONTROL);
    wire wr_refctl = do_write & sel(avs_address, `CDR_ADDR_REFCTL);
    wire [2:0] new_red = avs_writedata[`CDR_CD_RED_HI:`CDR_CD_RED_LO];

    // ------------------------------------------------------------------------
    // Clock divisor control register
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_recovery_reg        <= 1'b0;
            processor_clock_reduction_reg <= `CDR_CD_RST_RED;
            processor_clock_reduction_enable_reg               <= 1'b0;
            rc_osc_postscaler_reg         <= 3'h0;
            pll_output_divider_reg        <= `CDR_CD_RST_PLLD;
            pll_input_prescaler_reg       <= 5'h00;
        end else if (ce) begin
            if (wr_clock_divisor_control && wr_lo) begin
                pll_output_divider_reg  <= avs_writedata[`CDR_CD_PLLD_HI:`CDR_CD_PLLD_LO];
                pll_input_prescaler_reg <= avs_writedata[`CDR_CD_PRE_HI:`CDR_CD_PRE_LO];
            end
            if (wr_clock_divisor_control && wr_hi) begin
                interrupt_recovery_reg <= avs_writedata[`CDR_CD_RECOVER];
                rc_osc_postscaler_reg  <= avs_writedata[`CDR_CD_RCP_HI:`CDR_CD_RCP_LO];
                // Field frozen while processor_clock_reduction runs; old value is checked for set
                if (!processor_clock_reduction_enable_reg)
                    processor_clock_reduction_reg <= new_red;
            end
            // Interrupt exit beats a software write in the same cycle
            if (interrupt_recovery_reg && interrupt_event) begin
                processor_clock_reduction_enable_reg <= 1'b0;
            end else if (wr_clock_divisor_control && wr_hi) begin
                // Enable needs a nonzero ratio, taking the field as it will stand
                if (avs_writedata[`CDR_CD_PROCESSOR_CLOCK_REDUCTION_EN] &&
                    (processor_clock_reduction_enable_reg ? processor_clock_reduction_reg : new_red) == `CDR_RED_NONE)
                    processor_clock_reduction_enable_reg <= 1'b0;
                else
                    processor_clock_reduction_enable_reg <= avs_writedata[`CDR_CD_PROCESSOR_CLOCK_REDUCTION_EN];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Reference clock control register
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            refclk_out_enable_reg    <= 1'b0;
            refclk_sleep_run_reg     <= 1'b0;
            refclk_source_select_reg <= 1'b0;
            refclk_divider_reg       <= 4'h0;
        end else if (ce && wr_refctl && wr_hi) begin
            refclk_out_enable_reg    <= avs_writedata[`CDR_RC_ENABLE];
            refclk_sleep_run_reg     <= avs_writedata[`CDR_RC_SLEEP_RUN];
            refclk_source_select_reg <= avs_writedata[`CDR_RC_SOURCE];
            // Changing the divider while running may give one odd period
            refclk_divider_reg       <= avs_writedata[`CDR_RC_DIV_HI:`CDR_RC_DIV_LO];
        end
    end

    // ------------------------------------------------------------------------
    // Read back; unused and unmapped words read as zero
    // ------------------------------------------------------------------------
    assign clock_divisor_control_word = {interrupt_recovery_reg, processor_clock_reduction_reg, processor_clock_reduction_enable_reg,
                          rc_osc_postscaler_reg, pll_output_divider_reg, 1'b0, pll_input_prescaler_reg};
    assign refctl_word = {refclk_out_enable_reg, 1'b0, refclk_sleep_run_reg, refclk_source_select_reg,
                          refclk_divider_reg, 8'h00};

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h00000000;
        end else if (ce && avs_read && !do_read) begin
            // Loaded on the first edge so data stands while waitrequest is low
            case (avs_address)
                `CDR_ADDR_CLOCK_DIVISOR_CONTROL: avs_readdata <= {16'h0000, clock_divisor_control_word};
                `CDR_ADDR_REFCTL: avs_readdata <= {16'h0000, refctl_word};
                `CDR_ADDR_STATUS: avs_readdata <= {28'h0000000, refclk_out, processor_clock_reduction_enable_reg,
                                                   sleep_mode, refclk_out_enable_reg};
                default:          avs_readdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Peripheral clock: reduction ratio only while dozing
    // ------------------------------------------------------------------------
    wire [3:0] processor_clock_reduction_shift = processor_clock_reduction_enable_reg ? {1'b0, processor_clock_reduction_reg} : 4'h0;
    wire       processor_clock_reduction_tick;

    cdr_pow2_div u_processor_clock_reduction (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce & fcy_tick),
        .run     (1'b1),
        .shift   (processor_clock_reduction_shift),
        .tick    (processor_clock_reduction_tick),
        .level   ()
    );

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            periph_clk_tick <= 1'b0;
        else if (ce)
            periph_clk_tick <= processor_clock_reduction_tick & fcy_tick;
    end

    // ------------------------------------------------------------------------
    // RC oscillator postscaler: code n divides by 2 to the n
    // ------------------------------------------------------------------------
    wire rcp_raw;

    cdr_pow2_div u_rcp (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce & rc_osc_tick),
        .run     (1'b1),
        .shift   ({1'b0, rc_osc_postscaler_reg}),
        .tick    (rcp_raw),
        .level   ()
    );
    assign rc_osc_div_tick = rcp_raw & rc_osc_tick;

    // ------------------------------------------------------------------------
    // PLL output divider: 00 by 2, 01 by 4, 11 by 8; reserved code stops it
    // ------------------------------------------------------------------------
    wire [3:0] plld_shift = (pll_output_divider_reg == 2'h0) ? 4'h1 :
                            (pll_output_divider_reg == 2'h1) ? 4'h2 : 4'h3;
    wire       plld_raw;

    cdr_pow2_div u_plld (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce & pll_tick),
        .run     (pll_output_divider_reg != `CDR_PLLD_RSVD),
        .shift   (plld_shift),
        .tick    (plld_raw),
        .level   ()
    );
    assign pll_div_tick = plld_raw & pll_tick;

    // ------------------------------------------------------------------------
    // Reference clock output
    // ------------------------------------------------------------------------
    wire ref_src  = refclk_source_select_reg ? xtal_tick : sys_tick;
    wire ref_run  = refclk_out_enable_reg & (~sleep_mode | refclk_sleep_run_reg);
    wire ref_level;

    // Output is a square wave; its half period is the selected divide
    cdr_pow2_div u_ref (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce & ref_src),
        .run     (ref_run),
        .shift   (refclk_divider_reg),
        .tick    (),
        .level   (ref_level)
    );

    // Pin driven only while enabled; held low when stopped in Sleep
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            refclk_out      <= 1'b0;
            refclk_out_en_n <= 1'b1;
        end else if (ce) begin
            refclk_out      <= ref_run & ref_level;
            refclk_out_en_n <= ~refclk_out_enable_reg;
        end
    end

endmodule // cdr_clock_divisor

//--- tb/cdr_clock_divisor_sva.sv
// Port-level assertion checker for the clock divisor block
module cdr_clock_divisor_sva (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        ce,
    input wire logic [1:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        fcy_tick,
    input wire logic        rc_osc_tick,
    input wire logic        pll_tick,
    input wire logic        periph_clk_tick,
    input wire logic        rc_osc_div_tick,
    input wire logic        pll_div_tick,
    input wire logic        refclk_out,
    input wire logic        refclk_out_en_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Bus handshake and generated clocks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // One wait state: a pending request is acked on the next edge
    a_req_ack: assert property (ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest || !ce)
        else $error("request not acked after one wait state");
    a_idle_nowait: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
        else $error("waitrequest high with no request");
    a_unmapped_zero: assert property (ce && avs_read && !avs_waitrequest && avs_address == 2'h3
        |=> avs_readdata == 32'h0) else $error("unmapped word read not zero");
    // Read data must hold between reads so a slow master still sees it
    a_rdata_hold: assert property (!(ce && avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    a_rc_coincide: assert property (rc_osc_div_tick |-> rc_osc_tick)
        else $error("rc divided tick without source tick");
    a_pll_coincide: assert property (pll_div_tick |-> pll_tick)
        else $error("pll divided tick without source tick");
    a_periph_cause: assert property (periph_clk_tick |-> $past(fcy_tick))
        else $error("peripheral tick without preceding instruction tick");
    a_off_low: assert property (refclk_out_en_n && $past(refclk_out_en_n) |-> !refclk_out)
        else $error("reference output active while disabled");

    cover property (periph_clk_tick);
    cover property (!refclk_out_en_n && $rose(refclk_out));
    cover property (pll_div_tick);
endmodule // cdr_clock_divisor_sva

//--- tb/cdr_clock_divisor_tb_top.sv
// Directed testbench for the clock divisor block
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, a, e); end end

module cdr_clock_divisor_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [1:0]  avs_address = 2'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [4:0]  tk = 5'h0;
    logic        irq = 1'b0;
    logic        slp = 1'b0;
    logic        periph_clk_tick;
    logic        rc_osc_div_tick;
    logic        pll_div_tick;
    logic        refclk_out;
    logic        refclk_out_en_n;
    logic [31:0] rd;
    int          num_errors = 0;
    int          checks = 0;
    int          cp;
    int          cr;
    int          cl;
    int          co;
    int          pll_exp[4] = '{32, 16, 0, 8};

    initial begin
        forever #20 clk = ~clk;
    end

    // Ticks: fcy, rc, pll, xtal, sys from msb down
    cdr_clock_divisor u_cdr_clock_divisor (.clk, .reset_n, .ce(1'b1), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .fcy_tick(tk[4]),
        .rc_osc_tick(tk[3]), .pll_tick(tk[2]), .xtal_tick(tk[1]), .sys_tick(tk[0]), .interrupt_event(irq),
        .sleep_mode(slp), .periph_clk_tick, .rc_osc_div_tick, .pll_div_tick, .refclk_out, .refclk_out_en_n);

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic final_report;
        $display("Counts: checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Held until waitrequest is sampled low at a rising edge, then released
    task automatic bus(input logic w, input logic [1:0] a, input logic [15:0] d);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {16'h0, d};
        avs_read <= !w;
        avs_write <= w;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 20) begin
            num_errors++;
            $display("[ERR] t=%0t bus timeout", $time);
            final_report();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rdchk(input logic [1:0] a, input logic [31:0] e);
        bus(1'b0, a, 16'h0);
        `CHK(rd, e)
    endtask

    // Counts over n ticks plus two drain cycles; n a multiple of the ratio
    task automatic run(input logic [4:0] sel, input int n);
        logic p;
        cp = 0;
        cr = 0;
        cl = 0;
        co = 0;
        @(negedge clk);
        p = refclk_out;
        for (int k = 0; k < n + 2; k++) begin
            @(posedge clk);
            tk <= (k < n) ? sel : 5'h0;
            @(negedge clk);
            cp += periph_clk_tick;
            cr += rc_osc_div_tick;
            cl += pll_div_tick;
            co += (refclk_out !== p);
            p = refclk_out;
        end
    endtask

    // Divider only changed with the output disabled first
    task automatic refc(input logic [15:0] w, input logic [4:0] s, input logic sl, input int n, input int e);
        bus(1'b1, 2'h1, 16'h0000);
        bus(1'b1, 2'h1, w);
        slp <= sl;
        run(s, n);
        `CHK(co, e)
        `CHK(refclk_out_en_n, !w[15])
        $display("Test reference %h done, errors=%0d", w, num_errors);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        rdchk(2'h0, 32'h3040);
        rdchk(2'h1, 32'h0);
        rdchk(2'h3, 32'h0);
        for (logic [15:0] c = 0; c < 4; c++) begin
            bus(1'b1, 2'h0, 16'h3000 | (c << 6));
            run(5'h04, 64);
            `CHK(cl, pll_exp[c])
        end
        for (logic [15:0] c = 0; c < 8; c++) begin
            bus(1'b1, 2'h0, 16'h3040 | (c << 8));
            run(5'h08, 128);
            `CHK(cr, 128 >> c)
        end
        $display("Test dividers done, errors=%0d", num_errors);
        bus(1'b1, 2'h0, 16'h3840);
        run(5'h10, 64);
        `CHK(cp, 8)
        bus(1'b1, 2'h0, 16'h5840);
        rdchk(2'h0, 32'h3840);
        bus(1'b1, 2'h0, 16'h3040);
        run(5'h10, 64);
        `CHK(cp, 64)
        bus(1'b1, 2'h0, 16'h0840);
        rdchk(2'h0, 32'h0040);
        bus(1'b1, 2'h0, 16'hB840);
        @(posedge clk);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        rdchk(2'h0, 32'hB040);
        // Upper byte lane only, so the low byte must survive
        avs_byteenable <= 4'h2;
        bus(1'b1, 2'h0, 16'h0000);
        avs_byteenable <= 4'hF;
        rdchk(2'h0, 32'h0040);
        $display("Test processor_clock_reduction done, errors=%0d", num_errors);
        refc(16'h8000, 5'h01, 1'b0, 16, 16);
        refc(16'h8000, 5'h02, 1'b0, 16, 0);
        refc(16'h9200, 5'h02, 1'b0, 64, 16);
        refc(16'h9200, 5'h01, 1'b0, 64, 0);
        refc(16'h0100, 5'h01, 1'b0, 16, 0);
        refc(16'h8300, 5'h01, 1'b1, 64, 0);
        refc(16'hA300, 5'h01, 1'b1, 64, 8);
        refc(16'h8F00, 5'h01, 1'b0, 65536, 2);
        final_report();
    end
endmodule // cdr_clock_divisor_tb_top

bind cdr_clock_divisor cdr_clock_divisor_sva u_cdr_clock_divisor_sva (.clk, .reset_n, .ce, .avs_address,
    .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .fcy_tick, .rc_osc_tick, .pll_tick,
    .periph_clk_tick, .rc_osc_div_tick, .pll_div_tick, .refclk_out, .refclk_out_en_n);
